// >>> ssps_defines.svh
`ifndef SSPS_DEFINES_SVH
`define SSPS_DEFINES_SVH

// ==========================================================
// Register offsets
// ==========================================================
`define SSPS_OFS_BC_ERR      8'h1B
`define SSPS_OFS_PIN_LOW     8'h1C
`define SSPS_OFS_PIN_HIGH    8'h1D
`define SSPS_OFS_PORT_SEL    8'h1E
`define SSPS_OFS_FREQ_CNT    8'h1F

// ==========================================================
// Reset values
// ==========================================================
`define SSPS_RST_BC_ERR      8'h00
`define SSPS_RST_PORT_SEL    3'h1
`define SSPS_RST_FREQ_CNT    8'h00
`define SSPS_ZERO_BYTE       8'h00

// ==========================================================
// Field positions of the port select register
// ==========================================================
`define SSPS_SEL_FIRST_BIT   0
`define SSPS_SEL_SECOND_BIT  1
`define SSPS_SEL_ADDR2_BIT   2
`define SSPS_SEL_WIDTH       3

// ==========================================================
// Saturation limits and address step
// ==========================================================
`define SSPS_BC_ERR_MAX      8'hFF
`define SSPS_FREQ_MAX        8'hFF
`define SSPS_ADDR2_STEP      7'h01
`define SSPS_ONE_BYTE        8'h01

// ==========================================================
// Timing: oscillator tick against the 100 MHz clock
// ==========================================================
`define SSPS_CLK_PERIOD_NS   10
`define SSPS_OSC_PERIOD_NS   40
`define SSPS_OSC_TICK_CYC    ((`SSPS_OSC_PERIOD_NS + `SSPS_CLK_PERIOD_NS - 1) / `SSPS_CLK_PERIOD_NS)

`endif

// >>> ssps_pkg.sv
package ssps_pkg;

  // ==========================================================
  // Frequency counter sequencer states, one-hot
  // ==========================================================
  typedef enum logic [1:0] {
    SSPS_FC_IDLE = 2'b01,
    SSPS_FC_RUN  = 2'b10
  } ssps_fc_state_t;

endpackage : ssps_pkg

// >>> ssps_sync.sv
// ==========================================================
// Two-stage synchroniser for asynchronous inputs
// ==========================================================
module ssps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : ssps_sync

// >>> ssps_regs.sv
`include "ssps_defines.svh"

module ssps_regs #(
  parameter int          NUM_PORTS    = 2,
  parameter int          OSC_TICK_CYC = `SSPS_OSC_TICK_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Register access from the local I2C slave engine
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_via_second_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  output logic            reg_hit_o,
  // Slave address handling
  input  wire logic [6:0] dev_id_i,
  output logic      [6:0] second_addr_o,
  output logic            second_addr_en_o,
  // Port steering for the rest of the register map
  output logic            wr_first_port_o,
  output logic            wr_second_port_o,
  output logic            rd_second_port_o,
  // Self test error events, same clock domain
  input  wire logic       bist_start_i,
  input  wire logic       bist_active_i,
  input  wire logic       bc_crc_err_first_i,
  input  wire logic       bc_crc_err_second_i,
  input  wire logic       bc_err_clear_i,
  // Pin levels, asynchronous
  input  wire logic [3:0] local_line_i,
  input  wire logic       reg_line_five_i,
  input  wire logic       reg_line_six_i,
  input  wire logic       reg_line_seven_i,
  input  wire logic       reg_line_eight_i,
  input  wire logic       remote_line_zero_i,
  input  wire logic       remote_line_one_i,
  input  wire logic       remote_line_two_i,
  input  wire logic       remote_line_three_i,
  // Pixel clock sampled as a plain input
  input  wire logic       pixel_clk_i
);

  // ==========================================================
  // Port view helpers
  // ==========================================================

  // Second port is the target: address path wins over select bits
  function automatic logic ssps_second_view(
    input logic addr2_en,
    input logic via_second,
    input logic sel_bit
  );
    ssps_second_view = addr2_en ? via_second : sel_bit;
  endfunction : ssps_second_view

  // Byte equality on the register offset
  function automatic logic ssps_hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    ssps_hit = (addr == ofs);
  endfunction : ssps_hit

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int PIN_W = 13;

  logic [PIN_W-1:0] pin_async;
  logic [PIN_W-1:0] pin_sync;

  assign pin_async = {pixel_clk_i,
                      remote_line_three_i, remote_line_two_i,
                      remote_line_one_i, remote_line_zero_i,
                      reg_line_eight_i, reg_line_seven_i,
                      reg_line_six_i, reg_line_five_i,
                      local_line_i};

  ssps_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pin_async),
    .sync_o    (pin_sync)
  );

  // Named views of the synchronised levels
  logic [3:0] local_line_s;
  logic [2:0] reg_line_hi_s;
  logic       reg_line_eight_s;
  logic [3:0] remote_line_s;
  logic       pixel_clk_s;

  assign local_line_s     = pin_sync[3:0];
  assign reg_line_hi_s    = pin_sync[6:4];
  assign reg_line_eight_s = pin_sync[7];
  assign remote_line_s    = pin_sync[11:8];
  assign pixel_clk_s      = pin_sync[12];

  // ==========================================================
  // Address decode
  // ==========================================================
  logic hit_bc_err;
  logic hit_pin_low;
  logic hit_pin_high;
  logic hit_port_sel;
  logic hit_freq;
  logic wr_port_sel;
  logic wr_freq;

  assign hit_bc_err   = ssps_hit(reg_addr_i, `SSPS_OFS_BC_ERR);
  assign hit_pin_low  = ssps_hit(reg_addr_i, `SSPS_OFS_PIN_LOW);
  assign hit_pin_high = ssps_hit(reg_addr_i, `SSPS_OFS_PIN_HIGH);
  assign hit_port_sel = ssps_hit(reg_addr_i, `SSPS_OFS_PORT_SEL);
  assign hit_freq     = ssps_hit(reg_addr_i, `SSPS_OFS_FREQ_CNT);
  assign reg_hit_o    = hit_bc_err | hit_pin_low | hit_pin_high | hit_port_sel | hit_freq;

  // Only the two writable offsets accept writes
  assign wr_port_sel  = reg_wr_i & hit_port_sel;
  assign wr_freq      = reg_wr_i & hit_freq;

  // ==========================================================
  // Port select register
  // ==========================================================
  logic [`SSPS_SEL_WIDTH-1:0] port_sel_q;
  logic [`SSPS_SEL_WIDTH-1:0] port_sel_d;

  // Upper bits of the written byte are dropped
  assign port_sel_d = wr_port_sel ? reg_wdata_i[`SSPS_SEL_WIDTH-1:0] : port_sel_q;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_sel_q <= `SSPS_RST_PORT_SEL;
    else
      port_sel_q <= port_sel_d;
  end

  logic addr2_en;
  logic sel_first;
  logic sel_second;

  assign addr2_en   = port_sel_q[`SSPS_SEL_ADDR2_BIT];
  assign sel_first  = port_sel_q[`SSPS_SEL_FIRST_BIT];
  assign sel_second = port_sel_q[`SSPS_SEL_SECOND_BIT];

  // Second slave address is own address plus one
  assign second_addr_o    = dev_id_i + `SSPS_ADDR2_STEP;
  assign second_addr_en_o = addr2_en;

  // ==========================================================
  // Port steering
  // ==========================================================
  logic view_second;
  logic via_second_ok;

  // Second address only counts while it is enabled
  assign via_second_ok = addr2_en & reg_via_second_i;

  // Read view: second select wins over first select; both ignored with address two on
  assign view_second = ssps_second_view(addr2_en, via_second_ok, sel_second);

  // Write steering for the port-specific registers elsewhere
  assign wr_second_port_o = ssps_second_view(addr2_en, via_second_ok, sel_second);
  assign wr_first_port_o  = addr2_en ? ~reg_via_second_i : sel_first;
  assign rd_second_port_o = view_second;

  // ==========================================================
  // Back-channel error counters, one per port
  // ==========================================================
  logic [NUM_PORTS-1:0] crc_err;
  logic [7:0]           bc_err_q [NUM_PORTS];
  logic [7:0]           bc_err_d [NUM_PORTS];
  logic                 bc_clear;

  assign crc_err  = {bc_crc_err_second_i, bc_crc_err_first_i};
  assign bc_clear = bist_start_i | bc_err_clear_i;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_bc_err
      logic count_ev;

      // Errors only count while self test runs
      assign count_ev = bist_active_i & crc_err[gp];

      // An error in the clear cycle is kept as one
      assign bc_err_d[gp] = bc_clear ? (count_ev ? `SSPS_ONE_BYTE : `SSPS_RST_BC_ERR)
                          : (count_ev && bc_err_q[gp] != `SSPS_BC_ERR_MAX)
                          ? bc_err_q[gp] + `SSPS_ONE_BYTE
                          : bc_err_q[gp];

      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          bc_err_q[gp] <= `SSPS_RST_BC_ERR;
        else
          bc_err_q[gp] <= bc_err_d[gp];
      end
    end
  endgenerate

  // ==========================================================
  // Pin status views
  // ==========================================================
  logic [7:0] pin_low_val;
  logic [7:0] pin_high_val;
  logic [3:0] pin_low_nib;

  // Low nibble switches to remote lines with the second port viewed
  assign pin_low_nib  = view_second ? remote_line_s : local_line_s;
  // Bit 4 reserved reads zero; bits are raw levels, valid only for inputs
  assign pin_low_val  = {reg_line_hi_s, 1'b0, pin_low_nib};
  assign pin_high_val = {7'h00, reg_line_eight_s};

  // ==========================================================
  // Pixel clock frequency counter
  // ==========================================================
  localparam int PRE_W = (OSC_TICK_CYC > 1) ? $clog2(OSC_TICK_CYC) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_TICK_CYC - 1);

  ssps_pkg::ssps_fc_state_t fc_state_q;
  ssps_pkg::ssps_fc_state_t fc_state_d;
  logic [PRE_W-1:0]         pre_q;
  logic [PRE_W-1:0]         pre_d;
  logic [7:0]               ticks_q;
  logic [7:0]               ticks_d;
  logic [7:0]               freq_q;
  logic [7:0]               freq_d;
  logic                     pix_prev_q;
  logic                     pix_rise;
  logic                     osc_tick;
  logic                     fc_run;

  // Rising edge taken from the second synchroniser stage only
  assign pix_rise = pixel_clk_s & ~pix_prev_q;
  assign fc_run   = (fc_state_q == ssps_pkg::SSPS_FC_RUN);
  assign osc_tick = fc_run & (pre_q == PRE_LAST);

  // Interval sequencing; a new write restarts the interval
  always_comb
  begin
    fc_state_d = fc_state_q;
    pre_d      = pre_q;
    ticks_d    = ticks_q;
    freq_d     = freq_q;
    if (wr_freq)
    begin
      // Start fresh: zero length gives a zero count
      pre_d      = '0;
      ticks_d    = reg_wdata_i;
      freq_d     = `SSPS_RST_FREQ_CNT;
      fc_state_d = (reg_wdata_i == `SSPS_ZERO_BYTE) ? ssps_pkg::SSPS_FC_IDLE : ssps_pkg::SSPS_FC_RUN;
    end
    else
    begin
      unique case (fc_state_q)
        ssps_pkg::SSPS_FC_IDLE:
        begin
          pre_d = '0;
        end
        ssps_pkg::SSPS_FC_RUN:
        begin
          // Count edges, holding at the top value
          if (pix_rise && freq_q != `SSPS_FREQ_MAX)
            freq_d = freq_q + `SSPS_ONE_BYTE;
          if (osc_tick)
          begin
            pre_d   = '0;
            ticks_d = ticks_q - `SSPS_ONE_BYTE;
            if (ticks_q == `SSPS_ONE_BYTE)
              fc_state_d = ssps_pkg::SSPS_FC_IDLE;
          end
          else
            pre_d = pre_q + PRE_W'(1);
        end
        default:
        begin
          fc_state_d = ssps_pkg::SSPS_FC_IDLE;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      fc_state_q <= ssps_pkg::SSPS_FC_IDLE;
      pre_q      <= '0;
      ticks_q    <= `SSPS_ZERO_BYTE;
    end
    else
    begin
      fc_state_q <= fc_state_d;
      pre_q      <= pre_d;
      ticks_q    <= ticks_d;
    end
  end

  // Edge count and edge history
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      freq_q     <= `SSPS_RST_FREQ_CNT;
      pix_prev_q <= 1'b0;
    end
    else
    begin
      freq_q     <= freq_d;
      pix_prev_q <= pixel_clk_s;
    end
  end

  // ==========================================================
  // Read data path
  // ==========================================================
  logic [7:0] rd_val;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic [7:0] bc_err_view;

  assign bc_err_view = view_second ? bc_err_q[1] : bc_err_q[0];

  // Unmapped offsets and reserved bits read zero
  assign rd_val = hit_bc_err   ? bc_err_view
                : hit_pin_low  ? pin_low_val
                : hit_pin_high ? pin_high_val
                : hit_port_sel ? {5'h00, port_sel_q}
                : hit_freq     ? freq_q
                : `SSPS_ZERO_BYTE;

  // Data captured on the read strobe, valid one cycle later
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q  <= `SSPS_ZERO_BYTE;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i)
        rdata_q <= rd_val;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

endmodule : ssps_regs

// >>> ssps_regs_chk.sv
// ==========================================================
// Port checker for the register slice
// ==========================================================
module ssps_regs_chk (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_via_second_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       reg_rvalid_o,
  input  wire logic       reg_hit_o,
  input  wire logic [6:0] dev_id_i,
  input  wire logic [6:0] second_addr_o,
  input  wire logic       second_addr_en_o,
  input  wire logic       wr_first_port_o,
  input  wire logic       wr_second_port_o,
  input  wire logic       rd_second_port_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Request and answer steps
  sequence s_rd_req;
    reg_rd_i;
  endsequence
  sequence s_rd_ans;
    reg_rvalid_o;
  endsequence
  sequence s_sel_wr;
    reg_wr_i && reg_addr_i == 8'h1E;
  endsequence

  a_read_answered: assert property (s_rd_req |=> s_rd_ans)
    else $error("read not answered");
  a_rvalid_single: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("stray rvalid");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("rdata moved without read");
  a_unmapped_zero: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_high_reserved: assert property (reg_rd_i && reg_addr_i == 8'h1D |=> reg_rdata_o[7:1] == 7'h00)
    else $error("high status reserved bits set");
  a_low_reserved: assert property (reg_rd_i && reg_addr_i == 8'h1C |=> !reg_rdata_o[4])
    else $error("low status bit 4 set");
  a_hit_decode: assert property (reg_hit_o == (reg_addr_i >= 8'h1B && reg_addr_i <= 8'h1F))
    else $error("hit decode wrong");
  a_second_addr: assert property (second_addr_o == dev_id_i + 7'h01)
    else $error("second address not id plus one");
  a_addr2_steer: assert property (second_addr_en_o |->
    wr_second_port_o == reg_via_second_i && wr_first_port_o == !reg_via_second_i &&
    rd_second_port_o == reg_via_second_i)
    else $error("second address steering wrong");
  a_read_follow: assert property (rd_second_port_o == wr_second_port_o)
    else $error("read steering differs");
  a_select_view: assert property (reg_rvalid_o && $past(reg_addr_i) == 8'h1E && !reg_rdata_o[2] |->
    rd_second_port_o == reg_rdata_o[1] && wr_first_port_o == reg_rdata_o[0])
    else $error("select bits do not steer");
  a_enable_write: assert property (s_sel_wr |=> second_addr_en_o == $past(reg_wdata_i[2]))
    else $error("enable bit not written");
  a_enable_hold: assert property (!(reg_wr_i && reg_addr_i == 8'h1E) |=> $stable(second_addr_en_o))
    else $error("enable bit moved");
endmodule : ssps_regs_chk

bind ssps_regs ssps_regs_chk ssps_regs_chk_inst (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_via_second_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .dev_id_i, .second_addr_o,
  .second_addr_en_o, .wr_first_port_o, .wr_second_port_o, .rd_second_port_o);

// >>> ssps_host_model.sv
// ==========================================================
// Local host behind the slave engine, strobe side
// ==========================================================
module ssps_host_model (
  input  wire logic       clk_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_via_second_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_via_second_o = 1'b0;
  end

  // One write strobe; via second driven as given, left set after the strobe
  task wr_reg(input logic [7:0] a, input logic [7:0] d, input logic v);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_via_second_o = v;
    reg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr_reg

  // One read strobe, answer taken the cycle after
  task rd_reg(input logic [7:0] a, input logic v, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_via_second_o = v;
    reg_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    ok = reg_rvalid_i;
  endtask : rd_reg
endmodule : ssps_host_model

// >>> serializer_status_port_select_regs_tb.sv
module serializer_status_port_select_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals
  // ==========================================================
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic       reg_wr_i, reg_rd_i, reg_via_second_i, reg_rvalid_o, reg_hit_o;
  logic [6:0] dev_id_i = 7'h2C;
  logic [6:0] second_addr_o;
  logic       second_addr_en_o, wr_first_port_o, wr_second_port_o, rd_second_port_o;
  logic       bist_start_i = 1'b0;
  logic       bist_active_i = 1'b0;
  logic [1:0] err = 2'b00;
  logic       bc_err_clear_i = 1'b0;
  logic [3:0] local_line_i = 4'h0;
  logic [3:0] rem = 4'h0;
  logic [8:5] rl = 4'h0;
  logic       pixel_clk_i = 1'b0;
  int         fail_count = 0;
  int         compares = 0;

  // Clocks: 100 MHz system, free pixel clock near 33 MHz
  always #5 clk_i = ~clk_i;
  // Pixel edges kept 1 ns away from system clock edges
  initial
  begin
    #1;
    forever #15 pixel_clk_i = ~pixel_clk_i;
  end

  // ==========================================================
  // Design and host
  // ==========================================================
  ssps_regs #(.NUM_PORTS(2), .OSC_TICK_CYC(4)) ssps_regs_inst (.clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_via_second_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o,
    .dev_id_i, .second_addr_o, .second_addr_en_o, .wr_first_port_o, .wr_second_port_o,
    .rd_second_port_o, .bist_start_i, .bist_active_i, .bc_crc_err_first_i(err[0]),
    .bc_crc_err_second_i(err[1]), .bc_err_clear_i, .local_line_i, .reg_line_five_i(rl[5]),
    .reg_line_six_i(rl[6]), .reg_line_seven_i(rl[7]), .reg_line_eight_i(rl[8]),
    .remote_line_zero_i(rem[0]), .remote_line_one_i(rem[1]), .remote_line_two_i(rem[2]),
    .remote_line_three_i(rem[3]), .pixel_clk_i);

  ssps_host_model ssps_host_model_inst (.clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_via_second_o(reg_via_second_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

  // ==========================================================
  // Compare and helper tasks
  // ==========================================================
  task chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task wr(input logic [7:0] a, input logic [7:0] d);
    ssps_host_model_inst.wr_reg(a, d, 1'b0);
  endtask : wr

  task rd_exp(input logic [7:0] a, input logic [7:0] e, output logic [7:0] d);
    logic ok;
    ssps_host_model_inst.rd_reg(a, 1'b0, d, ok);
    chk_bit(ok, 1'b1, "rvalid");
    chk_byte(d, e, "rdata");
  endtask : rd_exp

  task err_pulses(input int n, input int p);
    repeat (n)
    begin
      tick(1);
      err[p] = 1'b1;
      tick(1);
      err[p] = 1'b0;
    end
  endtask : err_pulses

  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_select();
    logic [7:0] d;
    rd_exp(8'h1E, 8'h01, d);
    chk_bit(wr_first_port_o, 1'b1, "first after reset");
    ssps_host_model_inst.wr_reg(8'h1E, 8'hFF, 1'b1);
    tick(1);
    chk_bit(wr_second_port_o, 1'b1, "via second");
    chk_bit(wr_first_port_o, 1'b0, "selects ignored");
    rd_exp(8'h1E, 8'h07, d);
    wr(8'h1E, 8'h02);
    tick(1);
    chk_bit(wr_first_port_o, 1'b0, "only second");
    chk_bit(rd_second_port_o, 1'b1, "read second");
    wr(8'h1E, 8'h03);
    tick(1);
    chk_bit(wr_first_port_o, 1'b1, "both first");
    chk_bit(rd_second_port_o, 1'b1, "both read second");
    chk_byte({1'b0, second_addr_o}, 8'h2D, "second address");
    dev_id_i = 7'h7F;
    tick(1);
    chk_byte({1'b0, second_addr_o}, 8'h00, "address wrap");
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    rd_exp(8'h1E, 8'h01, d);
    $display("test select done");
  endtask : t_select

  task t_errors();
    logic [7:0] d;
    bist_active_i = 1'b1;
    err_pulses(3, 0);
    err_pulses(2, 1);
    bist_active_i = 1'b0;
    err_pulses(2, 0);
    rd_exp(8'h1B, 8'h03, d);
    wr(8'h1E, 8'h03);
    rd_exp(8'h1B, 8'h02, d);
    wr(8'h1E, 8'h01);
    wr(8'h1B, 8'h55);
    rd_exp(8'h1B, 8'h03, d);
    bc_err_clear_i = 1'b1;
    tick(1);
    bc_err_clear_i = 1'b0;
    rd_exp(8'h1B, 8'h00, d);
    bist_active_i = 1'b1;
    err_pulses(260, 0);
    rd_exp(8'h1B, 8'hFF, d);
    bist_start_i = 1'b1;
    tick(1);
    bist_start_i = 1'b0;
    rd_exp(8'h1B, 8'h00, d);
    bist_active_i = 1'b0;
    $display("test errors done");
  endtask : t_errors

  task t_pins();
    logic [7:0] d;
    rl = 4'b1011;
    local_line_i = 4'hA;
    rem = 4'h5;
    tick(3);
    rd_exp(8'h1C, 8'h6A, d);
    wr(8'h1C, 8'hFF);
    wr(8'h1E, 8'h03);
    rd_exp(8'h1C, 8'h65, d);
    wr(8'h1E, 8'h01);
    rd_exp(8'h1D, 8'h01, d);
    rd_exp(8'h20, 8'h00, d);
    $display("test pins done");
  endtask : t_pins

  task t_freq();
    logic [7:0] d;
    logic [7:0] d2;
    wr(8'h1F, 8'h00);
    tick(4);
    rd_exp(8'h1F, 8'h00, d);
    wr(8'h1F, 8'h19);
    tick(110);
    ssps_host_model_inst.rd_reg(8'h1F, 1'b0, d, d2[0]);
    chk_bit(d2[0], 1'b1, "rvalid");
    chk_bit(d >= 8'h20 && d <= 8'h23, 1'b1, "edge count");
    tick(20);
    rd_exp(8'h1F, d, d2);
    wr(8'h1F, 8'hFF);
    tick(1030);
    rd_exp(8'h1F, 8'hFF, d);
    $display("test freq done");
  endtask : t_freq

  // ==========================================================
  // Verdict
  // ==========================================================
  task summarize();
    $display("counts: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Watchdog
  initial
  begin
    #100us;
    fail_count++;
    $display("mismatch t=%0t watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial
  begin
    tick(12);
    sys_rst_i = 1'b0;
    t_select();
    t_errors();
    t_pins();
    t_freq();
    summarize();
  end
endmodule : serializer_status_port_select_regs_tb
